// ===== rtl/mpos_device.sv
// device end: power on/off sequencer
// What this block does
// - either control asserted enables regulators
// - after boot, processor holds regulators if asserted
// - valid power-down releases the regulator hold
// - release with level_a high enters off-mode
// - status low when off, high when on
// - key low 0.5 to 1.5 s turns on
// - key held past 1.5 s may power off
// - key low 2 s starts power-off
// - level_a high on, low off if level_a-started
// - host keeps level_a low unless using it
// - key-started device ignores level_a going low, unless level_a was high at the key start
// - level_a-started plus key off gives off-mode
// - level_a off ignored for 30 s after on
// - power-off stops companion and application interfaces
// - init first, then companion on and run in the same cycle
// - host ignores interfaces during system test
// - supply below minimum powers down silently
// - restart command acts like key power-off
// - stacked restart leaves companion powered
// - host uses level_a for firmware upgrade
// - off-mode keeps regulators, interfaces down, monitors inputs
`timescale 1ns/1ps
`default_nettype none
module mpos_device
   import mpos_pkg::*;
#(
   parameter int unsigned BOOT_CYC = mpos_pkg::BOOT_CYC_DEF,
   parameter int unsigned ON_MIN = mpos_pkg::ON_MIN_CYC,
   parameter int unsigned ON_MAX = mpos_pkg::ON_MAX_CYC,
   parameter int unsigned OFF_MIN = mpos_pkg::OFF_MIN_CYC,
   parameter int unsigned IGN_GUARD = mpos_pkg::IGN_GUARD_CYC
) (
   mpos_if.device link,
   input wire logic stacked,
   input wire logic supply_low,
   input wire logic module_restart_command,
   output logic regulator_en,
   output logic cpu_hold,
   output logic app_if_en,
   output logic companion_en,
   output logic slow_clock_mode,
   output logic system_test
);
   import mpos_pkg::*;

   mpos_state_type state_r;
   logic [CNT_W-1:0] key_cnt_r;
   logic [CNT_W-1:0] guard_cnt_r;
   logic [CNT_W-1:0] boot_cnt_r;
   logic key_low;
   logic key_start;
   logic key_off;
   logic by_ign_r;
   logic guard_done;
   logic hold_req;
   logic ign_off;
   logic ctrl_on;
   logic by_restart_r;

   assign key_low = !link.key_n;
   // press length in link.clk cycles
   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         key_cnt_r <= '0;
      end else if (!key_low) begin
         key_cnt_r <= '0;
      end else if (key_cnt_r != {CNT_W{1'b1}}) begin
         key_cnt_r <= key_cnt_r + 1'b1;
      end
   end
   // power on once press reaches 0.5 s; a press reaching 2 s goes on to off
   assign key_start = key_low && (key_cnt_r == CNT_W'(ON_MIN - 1));
   assign key_off = key_low && (key_cnt_r == CNT_W'(OFF_MIN - 1));

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         guard_cnt_r <= '0;
      end else if (state_r == MPOS_OFF || state_r == MPOS_OFFMODE) begin
         guard_cnt_r <= '0;
      end else if (!guard_done) begin
         guard_cnt_r <= guard_cnt_r + 1'b1;
      end
   end
   assign guard_done = (guard_cnt_r >= CNT_W'(IGN_GUARD));
   // level_a off honoured only when level_a-started and guard elapsed
   assign ign_off = by_ign_r && !link.level_a_in && guard_done;

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         boot_cnt_r <= '0;
      end else if (state_r == MPOS_BOOT) begin
         boot_cnt_r <= boot_cnt_r + 1'b1;
      end else begin
         boot_cnt_r <= '0;
      end
   end
   // hold taken only if a control still asserted after boot
   assign hold_req = key_low || link.level_a_in;

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         state_r <= MPOS_OFF;
         by_ign_r <= 1'b0;
      end else if (supply_low) begin
         state_r <= MPOS_OFF;
         by_ign_r <= 1'b0;
      end else begin
         unique case (state_r)
            MPOS_OFF, MPOS_OFFMODE: begin
               if (link.level_a_in && (state_r == MPOS_OFF)) begin
                  state_r <= MPOS_BOOT;
                  by_ign_r <= 1'b1;
               end else if (key_start) begin
                  state_r <= MPOS_BOOT;
                  by_ign_r <= link.level_a_in;
               end else if (state_r == MPOS_OFFMODE && !link.level_a_in) begin
                  state_r <= MPOS_OFF;
               end
            end
            MPOS_BOOT: begin
               if (boot_cnt_r == CNT_W'(BOOT_CYC - 1)) begin
                  state_r <= hold_req ? MPOS_ON : MPOS_OFF;
               end
            end
            MPOS_ON: begin
               if (key_off || module_restart_command || ign_off) begin
                  state_r <= MPOS_SHUTDOWN;
               end
            end
            MPOS_SHUTDOWN: begin
               // release hold; level_a still high keeps regulators
               state_r <= link.level_a_in ? MPOS_OFFMODE : MPOS_OFF;
            end
            default: begin
               state_r <= MPOS_OFF;
            end
         endcase
      end
   end

   // hardware phase: an asserted control enables the regulators
   assign ctrl_on = (link.level_a_in || key_low) && !supply_low;
   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         regulator_en <= 1'b0;
      end else begin
         regulator_en <= (state_r != MPOS_OFF) || ctrl_on;
      end
   end

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         cpu_hold <= 1'b0;
      end else begin
         cpu_hold <= (state_r == MPOS_ON);
      end
   end

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         app_if_en <= 1'b0;
      end else begin
         app_if_en <= (state_r == MPOS_ON);
      end
   end

   // restart is a pulse; remember it so the off states keep the companion
   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         by_restart_r <= 1'b0;
      end else if (supply_low) begin
         by_restart_r <= 1'b0;
      end else if (state_r == MPOS_ON) begin
         by_restart_r <= module_restart_command;
      end
   end

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         companion_en <= 1'b0;
      end else if (state_r == MPOS_ON && stacked) begin
         companion_en <= 1'b1;
      end else if (state_r == MPOS_SHUTDOWN || state_r == MPOS_OFF) begin
         // restart keeps companion up; other power-off stops it
         companion_en <= companion_en && by_restart_r && !supply_low;
      end else if (!stacked) begin
         companion_en <= 1'b0;
      end
   end

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         slow_clock_mode <= 1'b0;
      end else begin
         slow_clock_mode <= (state_r == MPOS_OFFMODE);
      end
   end

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         system_test <= 1'b0;
      end else begin
         system_test <= (state_r == MPOS_BOOT);
      end
   end

   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         link.powered <= RESET_STATUS;
      end else begin
         link.powered <= (state_r == MPOS_BOOT) || (state_r == MPOS_ON);
      end
   end
endmodule // mpos_device
`default_nettype wire

// ===== rtl/mpos_host.sv
// host end: drives power key and level_a on user requests
`timescale 1ns/1ps
`default_nettype none
module mpos_host
   import mpos_pkg::*;
#(
   parameter int unsigned PRESS_ON = mpos_pkg::ON_MIN_CYC + 1,
   parameter int unsigned PRESS_OFF = mpos_pkg::OFF_MIN_CYC + 1
) (
   mpos_if.host link,
   input wire logic key_on_req,
   input wire logic key_off_req,
   input wire logic ign_req,
   output logic busy,
   output logic powered_seen
);
   import mpos_pkg::*;

   logic [CNT_W-1:0] press_cnt_r;

   // level_a held low when unused, high for whole level_a use
   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         link.level_a_in <= 1'b0;
      end else begin
         link.level_a_in <= ign_req;
      end
   end

   // key pressed for a counted time inside the allowed window
   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         press_cnt_r <= '0;
         link.key_oe <= 1'b0;
         link.key_o <= 1'b1;
         busy <= 1'b0;
      end else if (press_cnt_r != '0) begin
         press_cnt_r <= press_cnt_r - 1'b1;
         if (press_cnt_r == CNT_W'(1)) begin
            link.key_oe <= 1'b0;
            busy <= 1'b0;
         end
      end else if (key_on_req || key_off_req) begin
         press_cnt_r <= key_off_req ? CNT_W'(PRESS_OFF) : CNT_W'(PRESS_ON);
         link.key_oe <= 1'b1;
         link.key_o <= 1'b0;
         busy <= 1'b1;
      end
   end

   // status is sampled only; toggling in system test is not acted on
   always_ff @(posedge link.clk) begin
      if (!link.resetn) begin
         powered_seen <= 1'b0;
      end else begin
         powered_seen <= link.powered;
      end
   end
endmodule // mpos_host
`default_nettype wire

// ===== rtl/mpos_if.sv
// interface: power key, level_a and powered status between host and device
`timescale 1ns/1ps
`default_nettype none
interface mpos_if (input wire logic clk, input wire logic resetn);
   logic key_o;
   logic key_oe;
   logic level_a_in;
   logic powered;
   logic key_n;
   assign key_n = (key_oe && !key_o) ? 1'b0 : 1'b1;
   modport device (input clk, input resetn, input key_n, input level_a_in, output powered);
   modport host (input clk, input resetn, output key_o, output key_oe, output level_a_in,
      input powered);
endinterface // mpos_if
`default_nettype wire

// ===== rtl/mpos_pkg.sv
// package: constants and types of the module power on/off sequencer
`default_nettype none
package mpos_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned ON_MIN_MS = 500;
   localparam int unsigned ON_MAX_MS = 1500;
   localparam int unsigned OFF_MIN_MS = 2000;
   localparam int unsigned IGN_GUARD_S = 30;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned ON_MIN_CYC = ON_MIN_MS * CYC_PER_MS;
   localparam int unsigned ON_MAX_CYC = ON_MAX_MS * CYC_PER_MS;
   localparam int unsigned OFF_MIN_CYC = OFF_MIN_MS * CYC_PER_MS;
   localparam int unsigned IGN_GUARD_CYC = IGN_GUARD_S * CLK_HZ;
   localparam int unsigned BOOT_CYC_DEF = 16;
   localparam int unsigned CNT_W = 32;
   localparam logic RESET_STATUS = 1'b0;
   typedef enum logic [2:0] {
      MPOS_OFF = 3'b000,
      MPOS_BOOT = 3'b001,
      MPOS_ON = 3'b011,
      MPOS_SHUTDOWN = 3'b010,
      MPOS_OFFMODE = 3'b110
   } mpos_state_type;
endpackage
`default_nettype wire

// ===== tb/mpos_link_chk.sv
// checker: power key, level_a and status relations on the link
`timescale 1ns/1ps
`default_nettype none
module mpos_link_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic key_o,
   input wire logic key_oe,
   input wire logic level_a_in,
   input wire logic powered,
   input wire logic key_n
);
   logic [7:0] key_cnt_r;
   logic [7:0] on_cnt_r;
   logic ign_start_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk) begin
      if (!resetn || key_n) key_cnt_r <= 8'h00;
      else if (key_cnt_r != 8'hff) key_cnt_r <= key_cnt_r + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (!resetn || !powered) on_cnt_r <= 8'h00;
      else if (on_cnt_r != 8'hff) on_cnt_r <= on_cnt_r + 8'h01;
   end
   // who started the current power-on
   always_ff @(posedge clk) begin
      if (!resetn) ign_start_r <= 1'b0;
      else if ($rose(powered)) ign_start_r <= level_a_in && key_n;
   end
   a_key_pull_up: assert property (!(key_oe && !key_o) |-> key_n)
      else $error("key line low while not driven");
   a_short_press: assert property ($rose(powered) && !$past(level_a_in) |-> $past(key_cnt_r) >= 8'h09)
      else $error("powered on after too short a press");
   a_rise_cause: assert property ($rose(powered) |-> $past(key_n) == 1'b0 || $past(level_a_in))
      else $error("powered on with no control asserted");
   a_ign_turn_on: assert property ($rose(level_a_in) && !powered && key_n |-> ##[1:3] powered)
      else $error("level_a did not power on");
   a_boot_hold: assert property ($rose(powered) |-> powered[*8])
      else $error("status dropped during boot");
   a_key_power_off: assert property (key_cnt_r == 8'h28 |-> ##[1:5] !powered)
      else $error("long key press did not power off");
   a_ign_ignored: assert property (powered && $fell(level_a_in) && on_cnt_r > 8'h0a
      && (on_cnt_r < 8'h5a || !ign_start_r) |=> powered)
      else $error("level_a low acted too early or on key start");
   a_ign_power_off: assert property (powered && ign_start_r && $fell(level_a_in)
      && on_cnt_r > 8'h69 |-> ##[1:4] !powered)
      else $error("level_a low did not power off");
endmodule // mpos_link_chk
`default_nettype wire

// ===== tb/tb_module_power_on_off_sequencer.sv
// testbench: host and device ends joined over the power link
`timescale 1ns/1ps
`default_nettype none
module tb_module_power_on_off_sequencer;
   import mpos_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, key_on_req = 1'b0, key_off_req = 1'b0, ign_req = 1'b0;
   logic stacked = 1'b0, supply_low = 1'b0, restart = 1'b0, prev_pwr = 1'b0;
   logic regulator_en, cpu_hold, app_if_en, companion_en, slow_clock_mode;
   logic system_test, busy, powered_seen, exp_pwr;
   logic note_q[$];
   int error_cnt = 0, compares = 0, cycles = 0;
   always #12.5 clk = ~clk;
   mpos_if u_mpos_if (.clk(clk), .resetn(resetn));
   mpos_device #(.ON_MIN(10), .OFF_MIN(40), .IGN_GUARD(100))
      u_mpos_device (.link(u_mpos_if), .stacked(stacked), .supply_low(supply_low),
      .module_restart_command(restart), .regulator_en(regulator_en), .cpu_hold(cpu_hold),
      .app_if_en(app_if_en), .companion_en(companion_en), .slow_clock_mode(slow_clock_mode),
      .system_test(system_test));
   // press outlasts the default boot so the hold decision sees the key
   mpos_host #(.PRESS_ON(28), .PRESS_OFF(41)) u_mpos_host (.link(u_mpos_if),
      .key_on_req(key_on_req), .key_off_req(key_off_req), .ign_req(ign_req), .busy(busy),
      .powered_seen(powered_seen));
   mpos_link_chk u_mpos_link_chk (.clk(clk), .resetn(resetn), .key_o(u_mpos_if.key_o),
      .key_oe(u_mpos_if.key_oe), .level_a_in(u_mpos_if.level_a_in),
      .powered(u_mpos_if.powered), .key_n(u_mpos_if.key_n));
   task automatic check(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic press(input bit on, input logic exp);
      note_q.push_back(exp);
      if (on) key_on_req <= 1'b1;
      else key_off_req <= 1'b1;
      cyc(1);
      key_on_req <= 1'b0;
      key_off_req <= 1'b0;
      cyc(1);
      check(busy, 1'b1);
      cyc(59);
      check(busy, 1'b0);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // status monitor and run limit
   always @(negedge clk) begin
      cycles++;
      if (resetn && u_mpos_if.powered !== prev_pwr) begin
         prev_pwr = u_mpos_if.powered;
         exp_pwr = ~prev_pwr;
         if (note_q.size() != 0) exp_pwr = note_q.pop_front();
         check(prev_pwr, exp_pwr);
         check(system_test, exp_pwr);
      end
      if (cycles > 2000) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         end_of_test();
      end
   end
   initial begin
      void'($urandom(63));
      cyc(10);
      stacked <= 1'($urandom_range(1, 0));
      resetn <= 1'b1;
      press(1'b1, 1'b1);
      check(cpu_hold, 1'b1);
      check(companion_en, stacked);
      check(app_if_en, 1'b1);
      check(system_test, 1'b0);
      check(powered_seen, 1'b1);
      $display("test 1 key on done");
      ign_req <= 1'b1;
      cyc(20);
      ign_req <= 1'b0;
      cyc(20);
      check(regulator_en, 1'b1);
      press(1'b0, 1'b0);
      check(regulator_en, 1'b0);
      check(app_if_en, 1'b0);
      check(companion_en, 1'b0);
      check(powered_seen, 1'b0);
      $display("test 2 key off done");
      note_q.push_back(1'b1);
      ign_req <= 1'b1;
      cyc(40);
      ign_req <= 1'b0;
      cyc(5);
      ign_req <= 1'b1;
      check(regulator_en, 1'b1);
      cyc(100);
      note_q.push_back(1'b0);
      ign_req <= 1'b0;
      cyc(10);
      check(regulator_en, 1'b0);
      $display("test 3 level_a done");
      note_q.push_back(1'b1);
      ign_req <= 1'b1;
      cyc(30);
      press(1'b0, 1'b0);
      check(regulator_en, 1'b1);
      check(slow_clock_mode, 1'b1);
      check(app_if_en, 1'b0);
      ign_req <= 1'b0;
      cyc(10);
      check(regulator_en, 1'b0);
      $display("test 4 off-mode done");
      press(1'b1, 1'b1);
      note_q.push_back(1'b0);
      restart <= 1'b1;
      cyc(1);
      restart <= 1'b0;
      cyc(10);
      check(cpu_hold, 1'b0);
      check(companion_en, stacked);
      press(1'b1, 1'b1);
      note_q.push_back(1'b0);
      supply_low <= 1'b1;
      cyc(5);
      check(regulator_en, 1'b0);
      supply_low <= 1'b0;
      cyc(5);
      $display("test 5 restart and supply loss done");
      end_of_test();
   end
endmodule // tb_module_power_on_off_sequencer
`default_nettype wire
